// [verilog/usac_pkg.sv]
// Package: register map, field positions, reset values and types of the USART control block
//
// Overview of operation
// - Halt transmitter after current character completes.
// - Without continuous select, sync clock toggles only during character activity.
// - Continuous select runs sync clock nonstop.
// - In sync mode, stop-on-receive clears continuous select and itself.
// - Measure first start bit, load divider.
// - Rate learning bit self-clears on done/error.
// - Disabled USART forces rate learning bit low.
// - Reserved control bits read zero, write zeros.
// - Writing one clears a clearable status flag.
// - Read-only flags ignore writes, maskable instead.
// - Halted flag set once transmit shifter idle, even with a byte held.
// - Receiver quiet flag high unless receiving.
package usac_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00; // Enable, sync mode
  localparam logic [7:0] ADDR_CONTROL = 8'h04; // operation_control
  localparam logic [7:0] ADDR_STATUS = 8'h08; // Status flags
  localparam logic [7:0] ADDR_IRQ_SET = 8'h0c; // Mask set (write ones)
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10; // irq_mask_clear_register
  localparam logic [7:0] ADDR_DIVIDER = 8'h20; // rate_divider_register
  localparam logic [7:0] ADDR_TXDATA = 8'h1c; // Transmit data
  localparam logic [7:0] ADDR_RXDATA = 8'h14; // Received data
  // Config fields
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_SYNC_BIT = 11;
  // Control fields
  localparam int CTL_HALT_BIT = 6;
  localparam int CTL_CONT_BIT = 8;
  localparam int CTL_STOPRX_BIT = 9;
  localparam int CTL_LEARN_BIT = 16;
  // Status fields
  localparam int ST_RXRDY_BIT = 0;
  localparam int ST_QUIET_BIT = 1;
  localparam int ST_TXRDY_BIT = 2;
  localparam int ST_TXIDLE_BIT = 3;
  localparam int ST_HALTED_BIT = 6;
  localparam int ST_START_BIT = 12;
  localparam int ST_FRAMERR_BIT = 13;
  localparam int ST_LEARNERR_BIT = 16;
  // Clearable sticky flags
  localparam logic [31:0] STAT_W1C_MASK = 32'h0001_3000;
  // Reset values
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // Oversampling per bit, and max start bit length before learning error
  localparam int OVERSAMPLE = 16;
  localparam logic [19:0] LEARN_MAX = 20'hfffff;
  // Line state machine
  typedef enum logic [1:0] {
    USAC_IDLE = 2'b00,
    USAC_START = 2'b01,
    USAC_DATA = 2'b10,
    USAC_STOP = 2'b11
  } usac_line_e;
  // Control register image
  typedef struct packed {
    logic learn;   // Rate learning enable
    logic stop_rx; // clock_stop_on_receive
    logic cont;    // continuous_clock_select
    logic halt;    // transmit_halt_request
  } usac_ctl_s;
endpackage

// [verilog/usac_top.sv]
// USART control upper bits, sync clock generation, rate learning, status and interrupt
`timescale 1ns/100ps
module usac_top #(
  parameter int DIV_W = 16 // Divider width
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic receive_line, // Serial receive pin
  output logic transmit_line, // Serial transmit pin
  output logic sclk_out, // Synchronous serial clock
  output logic sclk_oe, // Serial clock drive enable
  output logic irq // Level interrupt
);
  // Receive pin synchroniser; first stage read only by second
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= receive_line;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Register state
  logic enable_q, enable_d, sync_q, sync_d;
  usac_pkg::usac_ctl_s ctl_q, ctl_d;
  logic [31:0] stat_q, stat_d; // Sticky flags plus the halted level
  logic [31:0] mask_q, mask_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [7:0] txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
  logic txfull_q, txfull_d, rxrdy_q, rxrdy_d;

  // Engine state
  usac_pkg::usac_line_e txst_q, txst_d, rxst_q, rxst_d;
  logic [7:0] txsh_q, txsh_d, rxsh_q, rxsh_d;
  logic [2:0] txbit_q, txbit_d, rxbit_q, rxbit_d;
  logic [DIV_W+3:0] txcnt_q, txcnt_d, rxcnt_q, rxcnt_d;
  logic [19:0] lcnt_q, lcnt_d; // Start bit length counter
  logic lmeas_q, lmeas_d; // Measuring start bit
  logic txo_q, txo_d, sck_q, sck_d;
  logic [DIV_W+3:0] sckcnt_q, sckcnt_d;
  logic rx_prev_q;

  // Bus decode
  logic wr, rd, rx_done, tx_idle, rx_quiet, sclk_run;
  logic [DIV_W+3:0] bit_len;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1; // Zero wait states
  assign tx_idle = (txst_q == usac_pkg::USAC_IDLE) && !txfull_q;
  assign rx_quiet = (rxst_q == usac_pkg::USAC_IDLE);
  assign bit_len = {div_q, 4'h0} + (DIV_W+4)'(usac_pkg::OVERSAMPLE - 1); // Zero is counted too

  // Status image: live flags plus sticky ones
  function automatic logic [31:0] status_word(input logic [31:0] st);
    logic [31:0] w;
    w = st;
    w[usac_pkg::ST_RXRDY_BIT] = rxrdy_q;
    w[usac_pkg::ST_QUIET_BIT] = rx_quiet;
    w[usac_pkg::ST_TXRDY_BIT] = !txfull_q;
    w[usac_pkg::ST_TXIDLE_BIT] = tx_idle;
    return w;
  endfunction

  // Read mux; unmapped reads zero with error
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      usac_pkg::ADDR_CONFIG: begin
        prdata[usac_pkg::CFG_ENABLE_BIT] = enable_q;
        prdata[usac_pkg::CFG_SYNC_BIT] = sync_q;
      end
      usac_pkg::ADDR_CONTROL: begin
        // Reserved bits read zero
        prdata[usac_pkg::CTL_HALT_BIT] = ctl_q.halt;
        prdata[usac_pkg::CTL_CONT_BIT] = ctl_q.cont;
        prdata[usac_pkg::CTL_STOPRX_BIT] = ctl_q.stop_rx;
        prdata[usac_pkg::CTL_LEARN_BIT] = ctl_q.learn;
      end
      usac_pkg::ADDR_STATUS: prdata = status_word(stat_q);
      usac_pkg::ADDR_IRQ_SET: prdata = mask_q;
      usac_pkg::ADDR_IRQ_CLR: prdata = mask_q;
      usac_pkg::ADDR_RXDATA: prdata[7:0] = rxbuf_q;
      usac_pkg::ADDR_TXDATA: prdata[7:0] = txbuf_q;
      usac_pkg::ADDR_DIVIDER: prdata[DIV_W-1:0] = div_q;
      default: pslverr = psel && penable;
    endcase
  end

  // Interrupt: any unmasked status bit; process form so live flags inside the function wake it
  always_comb irq = |(status_word(stat_q) & mask_q);

  // Register next-state logic
  always_comb begin
    enable_d = enable_q;
    sync_d = sync_q;
    ctl_d = ctl_q;
    stat_d = stat_q;
    mask_d = mask_q;
    div_d = div_q;
    txbuf_d = txbuf_q;
    txfull_d = txfull_q;
    rxbuf_d = rxbuf_q;
    rxrdy_d = rxrdy_q;
    if (wr) begin
      case (paddr)
        usac_pkg::ADDR_CONFIG: begin
          enable_d = pwdata[usac_pkg::CFG_ENABLE_BIT];
          sync_d = pwdata[usac_pkg::CFG_SYNC_BIT];
        end
        usac_pkg::ADDR_CONTROL: begin
          ctl_d.halt = pwdata[usac_pkg::CTL_HALT_BIT];
          ctl_d.cont = pwdata[usac_pkg::CTL_CONT_BIT];
          ctl_d.stop_rx = pwdata[usac_pkg::CTL_STOPRX_BIT];
          // Learning bit only changes while receiver idle
          if (rx_quiet) begin
            ctl_d.learn = pwdata[usac_pkg::CTL_LEARN_BIT] && enable_q;
          end
        end
        // Write one clears; read-only flags untouched
        usac_pkg::ADDR_STATUS: stat_d = stat_q & ~(pwdata & usac_pkg::STAT_W1C_MASK);
        usac_pkg::ADDR_IRQ_SET: mask_d = mask_q | pwdata;
        usac_pkg::ADDR_IRQ_CLR: mask_d = mask_q & ~pwdata;
        usac_pkg::ADDR_DIVIDER: div_d = pwdata[DIV_W-1:0];
        usac_pkg::ADDR_TXDATA: begin
          txbuf_d = pwdata[7:0];
          txfull_d = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd && paddr == usac_pkg::ADDR_RXDATA) begin
      rxrdy_d = 1'b0;
    end
    // Hardware events win over software clear
    if (txst_q == usac_pkg::USAC_IDLE && txfull_q && !ctl_q.halt) begin
      txfull_d = 1'b0; // Buffer moves to shifter, or is dropped while the USART is disabled
    end
    if (ctl_q.halt && txst_q == usac_pkg::USAC_IDLE) begin // A held byte does not keep it busy
      stat_d[usac_pkg::ST_HALTED_BIT] = 1'b1;
    end else begin
      stat_d[usac_pkg::ST_HALTED_BIT] = 1'b0; // Read-only level
    end
    if (rxst_q == usac_pkg::USAC_IDLE && rx_prev_q && !rx_s2_q) begin
      stat_d[usac_pkg::ST_START_BIT] = 1'b1;
    end
    if (rx_done) begin
      rxbuf_d = rxsh_q;
      rxrdy_d = 1'b1;
      if (!rx_s2_q) begin
        stat_d[usac_pkg::ST_FRAMERR_BIT] = 1'b1;
      end
      if (sync_q && ctl_q.stop_rx) begin
        ctl_d.cont = 1'b0;
        ctl_d.stop_rx = 1'b0;
      end
    end
    // Rate learning completion and error
    if (lmeas_q && rx_s2_q) begin
      div_d = DIV_W'((lcnt_q >> 4) - 20'h1);
      ctl_d.learn = 1'b0;
    end else if (lmeas_q && lcnt_q == usac_pkg::LEARN_MAX) begin
      stat_d[usac_pkg::ST_LEARNERR_BIT] = 1'b1;
      ctl_d.learn = 1'b0;
    end
    if (!enable_d) begin
      ctl_d.learn = 1'b0;
    end
  end

  // Receive next-state, with start bit measurement
  always_comb begin
    rxst_d = rxst_q;
    rxsh_d = rxsh_q;
    rxbit_d = rxbit_q;
    rxcnt_d = rxcnt_q;
    lcnt_d = lcnt_q;
    lmeas_d = lmeas_q;
    rx_done = 1'b0;
    if (lmeas_q) begin
      // Learning owns the line until start bit ends
      lcnt_d = lcnt_q + 20'h1;
      if (rx_s2_q || lcnt_q == usac_pkg::LEARN_MAX) begin
        lmeas_d = 1'b0;
      end
    end else begin
      case (rxst_q)
        usac_pkg::USAC_IDLE: begin
          if (enable_q && rx_prev_q && !rx_s2_q) begin
            if (ctl_q.learn) begin
              lmeas_d = 1'b1;
              lcnt_d = 20'h1;
            end else begin
              rxst_d = usac_pkg::USAC_START;
              rxcnt_d = bit_len >> 1;
            end
          end
        end
        usac_pkg::USAC_START: begin
          rxcnt_d = rxcnt_q - 1'b1;
          if (rxcnt_q == '0) begin
            rxst_d = rx_s2_q ? usac_pkg::USAC_IDLE : usac_pkg::USAC_DATA;
            rxcnt_d = bit_len;
            rxbit_d = 3'h0;
          end
        end
        usac_pkg::USAC_DATA: begin
          rxcnt_d = rxcnt_q - 1'b1;
          if (rxcnt_q == '0) begin
            rxsh_d = {rx_s2_q, rxsh_q[7:1]};
            rxcnt_d = bit_len;
            rxbit_d = rxbit_q + 3'h1;
            if (rxbit_q == 3'h7) begin
              rxst_d = usac_pkg::USAC_STOP;
            end
          end
        end
        usac_pkg::USAC_STOP: begin
          rxcnt_d = rxcnt_q - 1'b1;
          if (rxcnt_q == '0) begin
            rx_done = 1'b1;
            rxst_d = usac_pkg::USAC_IDLE;
          end
        end
        default: rxst_d = usac_pkg::USAC_IDLE;
      endcase
    end
  end

  // Transmit next-state; halt only takes effect between characters
  always_comb begin
    txst_d = txst_q;
    txsh_d = txsh_q;
    txbit_d = txbit_q;
    txcnt_d = txcnt_q;
    txo_d = txo_q;
    case (txst_q)
      usac_pkg::USAC_IDLE: begin
        txo_d = 1'b1;
        if (txfull_q && !ctl_q.halt && enable_q) begin
          txst_d = usac_pkg::USAC_START;
          txsh_d = txbuf_q;
          txcnt_d = bit_len;
          txo_d = 1'b0;
        end
      end
      usac_pkg::USAC_START, usac_pkg::USAC_DATA: begin
        txcnt_d = txcnt_q - 1'b1;
        if (txcnt_q == '0) begin
          txcnt_d = bit_len;
          txo_d = txsh_q[0];
          txsh_d = {1'b1, txsh_q[7:1]};
          txbit_d = (txst_q == usac_pkg::USAC_START) ? 3'h0 : txbit_q + 3'h1;
          if (txst_q == usac_pkg::USAC_START) begin
            txst_d = usac_pkg::USAC_DATA;
          end else if (txbit_q == 3'h7) begin
            txst_d = usac_pkg::USAC_STOP;
            txo_d = 1'b1;
          end
        end
      end
      usac_pkg::USAC_STOP: begin
        txcnt_d = txcnt_q - 1'b1;
        if (txcnt_q == '0) begin
          txst_d = usac_pkg::USAC_IDLE; // Character complete
        end
      end
      default: txst_d = usac_pkg::USAC_IDLE;
    endcase
  end

  // Serial clock: per character or continuous; async mode keeps it idle
  assign sclk_run = sync_q && enable_q &&
                    (ctl_q.cont ||
                     txst_q != usac_pkg::USAC_IDLE || !rx_quiet);
  always_comb begin
    sckcnt_d = sckcnt_q;
    sck_d = 1'b0;
    if (sclk_run) begin
      sckcnt_d = sckcnt_q + 1'b1;
      sck_d = sck_q;
      if (sckcnt_q >= (bit_len >> 1)) begin
        sckcnt_d = '0;
        sck_d = !sck_q;
      end
    end else begin
      sckcnt_d = '0;
    end
  end
  assign sclk_out = sck_q;
  assign sclk_oe = sync_q && enable_q;
  assign transmit_line = txo_q;

  // All state registers except the receive synchroniser
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= 1'b0;
      sync_q <= 1'b0;
      ctl_q <= '0;
      stat_q <= 32'h0000_0000;
      mask_q <= usac_pkg::MASK_RESET;
      div_q <= DIV_W'(usac_pkg::DIVIDER_RESET);
      txbuf_q <= 8'h00;
      txfull_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rxrdy_q <= 1'b0;
      txst_q <= usac_pkg::USAC_IDLE;
      rxst_q <= usac_pkg::USAC_IDLE;
      txsh_q <= 8'hff;
      rxsh_q <= 8'h00;
      txbit_q <= 3'h0;
      rxbit_q <= 3'h0;
      txcnt_q <= '0;
      rxcnt_q <= '0;
      lcnt_q <= 20'h0;
      lmeas_q <= 1'b0;
      txo_q <= 1'b1;
      sck_q <= 1'b0;
      sckcnt_q <= '0;
      rx_prev_q <= 1'b1;
    end else begin
      enable_q <= enable_d;
      sync_q <= sync_d;
      ctl_q <= ctl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      div_q <= div_d;
      txbuf_q <= txbuf_d;
      txfull_q <= txfull_d;
      rxbuf_q <= rxbuf_d;
      rxrdy_q <= rxrdy_d;
      txst_q <= txst_d;
      rxst_q <= rxst_d;
      txsh_q <= txsh_d;
      rxsh_q <= rxsh_d;
      txbit_q <= txbit_d;
      rxbit_q <= rxbit_d;
      txcnt_q <= txcnt_d;
      rxcnt_q <= rxcnt_d;
      lcnt_q <= lcnt_d;
      lmeas_q <= lmeas_d;
      txo_q <= txo_d;
      sck_q <= sck_d;
      sckcnt_q <= sckcnt_d;
      rx_prev_q <= rx_s2_q;
    end
  end
endmodule

// [verification/usac_top_assertions.sv]
// Checker: port-level properties of the USART control block
`timescale 1ns/100ps
module usac_top_assertions (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic transmit_line, // Serial out
  input wire logic sclk_out, // Sync clock
  input wire logic sclk_oe, // Sync clock enable
  input wire logic irq // Interrupt
);
  logic [31:0] mask_q, mask_d; // Mirror of the interrupt mask
  logic en_q, en_d, sync_q, sync_d; // Mirror of enable and sync mode
  logic wr, mapped; // Completed write, decoded address
  assign wr = psel && penable && pwrite && pready;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20};
  // Next mirror values, taken only from completed writes
  always_comb begin
    mask_d = mask_q;
    en_d = en_q;
    sync_d = sync_q;
    if (wr && paddr == usac_pkg::ADDR_IRQ_SET) mask_d = mask_q | pwdata;
    if (wr && paddr == usac_pkg::ADDR_IRQ_CLR) mask_d = mask_q & ~pwdata;
    if (wr && paddr == usac_pkg::ADDR_CONFIG) begin
      en_d = pwdata[usac_pkg::CFG_ENABLE_BIT];
      sync_d = pwdata[usac_pkg::CFG_SYNC_BIT];
    end
  end
  // Mirror registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= 32'h0;
      en_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      en_q <= en_d;
      sync_q <= sync_d;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_read_ctl;
    s_access ##0 (!pwrite && paddr == usac_pkg::ADDR_CONTROL);
  endsequence
  property p_zero_wait;
    s_access |-> pready;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access phase without ready");
  property p_unmapped;
    s_access ##0 !mapped |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    s_access ##0 mapped |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_ctl_reserved;
    s_read_ctl |-> (prdata & 32'hfffe_fc80) == 32'h0;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bit read as one");
  property p_irq_masked;
    (mask_q == 32'h0) && ($past(mask_q) == 32'h0) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with empty mask");
  property p_learn_off;
    s_read_ctl ##0 (!en_q && !$past(en_q)) |-> !prdata[usac_pkg::CTL_LEARN_BIT];
  endproperty
  a_learn_off: assert property (p_learn_off) else $error("learning bit while disabled");
  property p_sclk_on;
    (sync_q && en_q) [*2] |-> sclk_oe;
  endproperty
  a_sclk_on: assert property (p_sclk_on) else $error("sync clock not driven");
  property p_sclk_async;
    (!sync_q || !en_q) [*3] |-> !sclk_oe && !sclk_out;
  endproperty
  a_sclk_async: assert property (p_sclk_async) else $error("sync clock in async mode");
  property p_start_len;
    $fell(transmit_line) |-> !transmit_line [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
endmodule
bind usac_top usac_top_assertions chk_u (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .transmit_line, .sclk_out, .sclk_oe, .irq);

// [verification/usac_remote.sv]
// Remote serial device: frames onto the receive line, captures the transmit line
`timescale 1ns/100ps
module usac_remote (
  input wire logic ref_clk, // Clock
  output logic receive_line, // Line into the block
  input wire logic transmit_line // Line out of the block
);
  logic [7:0] got_byte; // Last captured character
  int got_count = 0; // Framed characters captured
  int bit_cyc = 16; // Cycles per bit expected from the block
  initial receive_line = 1'b1;
  // One frame, LSB first; line rests high afterwards as an idle line should
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      receive_line <= f[i];
      repeat (cyc - 1) @(posedge ref_clk);
    end
  endtask
  // Mid-bit sampling; a frame without stop bit is not counted
  always begin
    @(negedge transmit_line);
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      got_byte[i] = transmit_line;
    end
    repeat (bit_cyc) @(posedge ref_clk);
    if (transmit_line) got_count++;
  end
endmodule

// [verification/usart_control_autobaud_sync_clock_tb.sv]
// Testbench: register-level tests of the USART control block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module usart_control_autobaud_sync_clock_tb;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, err; // Bus and flags
  logic receive_line, transmit_line, sclk_out, sclk_oe, irq; // Line side
  logic [7:0] paddr; // Address
  logic [31:0] pwdata, prdata, rd; // Data
  int bad_count, check_count, sclk_edges, n; // Counters
  usac_top dut_u (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .receive_line, .transmit_line, .sclk_out, .sclk_oe, .irq);
  usac_remote remote_u (.ref_clk, .receive_line, .transmit_line);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(sclk_out) sclk_edges++;
  // One APB transfer; data taken at the completing edge, then a half cycle for outputs to settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Ends at the first edge with pready high; the watchdog covers a stall
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  // Read and compare under a mask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd & m)
  endtask
  task automatic wait_got(input int c);
    for (int k = 0; k < 3000 && remote_u.got_count < c; k++) @(posedge ref_clk);
  endtask
  task automatic sclk_count(input int c, output int e);
    e = sclk_edges;
    repeat (c) @(posedge ref_clk);
    e = sclk_edges - e;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well beyond the expected run of some five thousand cycles
  initial begin
    repeat (80000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {bad_count, check_count, sclk_edges} = '0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rdchk(usac_pkg::ADDR_CONTROL, 32'hffff_ffff, 32'h0, "control reset");
    rdchk(usac_pkg::ADDR_STATUS, 32'h0001_304f, 32'h0000_000e, "status reset");
    rdchk(usac_pkg::ADDR_DIVIDER, 32'h0000_ffff, 32'h0, "divider reset");
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h0001_0340);
    rdchk(usac_pkg::ADDR_CONTROL, 32'hffff_ffff, 32'h0000_0340, "control bits");
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h0);
    $display("test reset and register done");
    // Halt arrives mid-character: that character completes, the next one waits
    apb(1'b1, usac_pkg::ADDR_CONFIG, 32'h1);
    apb(1'b1, usac_pkg::ADDR_TXDATA, 32'ha5);
    wait_got(1);
    `CHK("tx byte", 8'ha5, remote_u.got_byte)
    apb(1'b1, usac_pkg::ADDR_TXDATA, 32'h5a);
    repeat (40) @(posedge ref_clk);
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h40);
    wait_got(2);
    `CHK("tx byte", 8'h5a, remote_u.got_byte)
    repeat (40) @(posedge ref_clk);
    rdchk(usac_pkg::ADDR_STATUS, 32'h40, 32'h40, "halted flag");
    apb(1'b1, usac_pkg::ADDR_TXDATA, 32'hc3);
    repeat (400) @(posedge ref_clk);
    `CHK("frames while halted", 2, remote_u.got_count)
    apb(1'b1, usac_pkg::ADDR_IRQ_SET, 32'h40);
    `CHK("irq halted", 1'b1, irq)
    apb(1'b1, usac_pkg::ADDR_STATUS, 32'h40);
    rdchk(usac_pkg::ADDR_STATUS, 32'h40, 32'h40, "halted after write");
    apb(1'b1, usac_pkg::ADDR_IRQ_CLR, 32'h40);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h0);
    wait_got(3);
    `CHK("tx byte", 8'hc3, remote_u.got_byte)
    rdchk(usac_pkg::ADDR_STATUS, 32'h40, 32'h0, "halted released");
    $display("test halt done");
    // Receive: quiet flag, start flag clear by one, interrupt
    apb(1'b1, usac_pkg::ADDR_IRQ_SET, 32'h1000);
    fork
      remote_u.send(8'h3c, 16);
      begin
        repeat (60) @(posedge ref_clk);
        rdchk(usac_pkg::ADDR_STATUS, 32'h2, 32'h0, "quiet busy");
      end
    join
    repeat (20) @(posedge ref_clk);
    rdchk(usac_pkg::ADDR_STATUS, 32'h1003, 32'h1003, "after rx");
    `CHK("irq start", 1'b1, irq)
    apb(1'b1, usac_pkg::ADDR_STATUS, 32'h0);
    rdchk(usac_pkg::ADDR_STATUS, 32'h1000, 32'h1000, "start kept");
    apb(1'b1, usac_pkg::ADDR_STATUS, 32'h1000);
    rdchk(usac_pkg::ADDR_STATUS, 32'h1000, 32'h0, "start cleared");
    `CHK("irq cleared", 1'b0, irq)
    rdchk(usac_pkg::ADDR_RXDATA, 32'hff, 32'h3c, "rx byte");
    $display("test receive done");
    // Rate learning: a 64-cycle start bit means divider 3
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h1_0000);
    rdchk(usac_pkg::ADDR_CONTROL, 32'h1_0000, 32'h1_0000, "learn set");
    remote_u.send(8'hff, 64);
    repeat (20) @(posedge ref_clk);
    rdchk(usac_pkg::ADDR_DIVIDER, 32'hffff, 32'h3, "divider");
    rdchk(usac_pkg::ADDR_CONTROL, 32'h1_0000, 32'h0, "learn done");
    remote_u.send(8'h96, 64);
    repeat (20) @(posedge ref_clk);
    rdchk(usac_pkg::ADDR_RXDATA, 32'hff, 32'h96, "rx new rate");
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h1_0000);
    apb(1'b1, usac_pkg::ADDR_CONFIG, 32'h0);
    rdchk(usac_pkg::ADDR_CONTROL, 32'h1_0000, 32'h0, "learn disabled");
    $display("test learning done");
    // Synchronous clock modes
    remote_u.bit_cyc = 64;
    apb(1'b1, usac_pkg::ADDR_CONFIG, 32'h801);
    `CHK("sclk enable", 1'b1, sclk_oe)
    sclk_count(300, n);
    `CHK("sclk idle", 0, n)
    apb(1'b1, usac_pkg::ADDR_TXDATA, 32'h11);
    sclk_count(300, n);
    `CHK("sclk on tx", 1'b1, n > 5)
    wait_got(4);
    `CHK("sync tx byte", 8'h11, remote_u.got_byte)
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h100);
    sclk_count(300, n);
    `CHK("sclk continuous", 1'b1, n > 5)
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h300);
    remote_u.send(8'h81, 64);
    repeat (20) @(posedge ref_clk);
    rdchk(usac_pkg::ADDR_CONTROL, 32'h300, 32'h0, "auto clear");
    repeat (100) @(posedge ref_clk);
    sclk_count(300, n);
    `CHK("sclk stopped", 0, n)
    apb(1'b1, usac_pkg::ADDR_CONFIG, 32'h1);
    apb(1'b1, usac_pkg::ADDR_CONTROL, 32'h100);
    sclk_count(300, n);
    `CHK("sclk async", 0, n)
    `CHK("sclk enable async", 1'b0, sclk_oe)
    $display("test sync clock done");
    tally_and_finish();
  end
endmodule
